// *** rpc_relay_pi.sv ***
// relay pi controller top: axi4-lite registers, output percentage, relay timing
//
// Contract
// - three modes: on/off, pulse width, frequency
// - on/off mode ignores pi settings
// - pulse width varies on/off ratio
// - frequency mode keeps fixed on length
// - more demand shortens off interval
// - one span shared by all relays
// - gain one, span deviation gives 100%
// - deviation beyond span saturates at 100%
// - output tracks setpoint continuously
// - higher gain lengthens or shortens on time
// - negative gain inverts action
// - gain signed, thousandths, -32.768 to 32.767
// - output change scales with gain
// - half bias at setpoint gives half duty
// - positive gain far above: permanently released
// - negative gain far above: permanently energised
// - period sets cycle length, 0 to 5000 s
// - zero pulse length disables frequency output
// - bias sets duty at setpoint, 0-100%
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "rpc_map.svh"

module rpc_relay_pi #(
    parameter int N_RELAY = 2,
    parameter int TICK_CYCLES = `RPC_TICK_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // process value and relays
    input wire logic [15:0] process_value,
    output logic [N_RELAY-1:0] relay_on
);
    import rpc_pkg::*;

    typedef struct packed {
        logic [15:0] span;
        rpc_relay_cfg_t [N_RELAY-1:0] cfg;
        logic [N_RELAY-1:0][10:0] duty;
        logic [31:0] presc;
        logic tick;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rpc_top_state_t;

    rpc_top_state_t s;
    rpc_top_state_t next_s;
    logic [N_RELAY-1:0][10:0] calc_duty;
    logic [N_RELAY-1:0] below;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = d[7:0];
        end
        if (strb[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    // output percentage in tenths of a percent
    genvar g;
    generate
        for (g = 0; g < N_RELAY; g++) begin : g_relay
            logic signed [16:0] err;
            logic signed [33:0] prod;
            logic signed [33:0] quot;
            logic signed [33:0] sum;
            logic signed [16:0] span_div;
            always_comb begin
                err = $signed({s.cfg[g].setpoint[15], s.cfg[g].setpoint})
                    - $signed({process_value[15], process_value});
                prod = 34'($signed(s.cfg[g].gain) * err);
                span_div = (s.span == 16'h0000) ? 17'sh00001 : $signed({1'b0, s.span});
                quot = prod / 34'(span_div);
                sum = $signed({23'h000000, s.cfg[g].bias}) + quot;
                if (sum < 0) begin
                    calc_duty[g] = 11'h000;
                end else if (sum > 34'($signed({1'b0, `RPC_FULL_SCALE}))) begin
                    calc_duty[g] = `RPC_FULL_SCALE;
                end else begin
                    calc_duty[g] = sum[10:0];
                end
                below[g] = $signed(process_value) < $signed(s.cfg[g].setpoint);
            end

            rpc_relay_channel u_chan (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(s.tick),
                .cfg(s.cfg[g]),
                .duty(s.duty[g]),
                .below_setpoint(below[g]),
                .relay_on(relay_on[g])
            );
        end
    endgenerate

    always_comb begin
        logic [7:0] rbase;
        logic hit;
        next_s = s;
        rbase = 8'h00;
        hit = 1'b0;
        next_s.duty = calc_duty;
        next_s.tick = 1'b0;
        if (s.presc >= 32'(TICK_CYCLES - 1)) begin
            next_s.presc = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.presc = s.presc + 32'h1;
        end
        // write channel capture, either order
        if (!s.aw_held && awvalid) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (!s.w_held && wvalid) begin
            next_s.w_held = 1'b1;
            next_s.w_data = wdata;
            next_s.w_strb = wstrb;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_held && s.w_held && !s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            if (s.aw_addr == `RPC_SPAN_OFF) begin
                next_s.span = merge16(s.span, s.w_data, s.w_strb);
                hit = 1'b1;
            end
            for (int i = 0; i < N_RELAY; i++) begin
                rbase = 8'(`RPC_RELAY_BASE + i * `RPC_RELAY_STRIDE);
                if (s.aw_addr == rbase + `RPC_MODE_OFF) begin
                    hit = 1'b1;
                    if (s.w_strb[0]) begin
                        unique case (s.w_data[1:0])
                            2'h1: next_s.cfg[i].mode = RPC_PULSE_WIDTH;
                            2'h2: next_s.cfg[i].mode = RPC_FREQUENCY;
                            default: next_s.cfg[i].mode = RPC_ON_OFF;
                        endcase
                    end
                end
                if (s.aw_addr == rbase + `RPC_SETPOINT_OFF) begin
                    hit = 1'b1;
                    next_s.cfg[i].setpoint = merge16(s.cfg[i].setpoint, s.w_data, s.w_strb);
                end
                if (s.aw_addr == rbase + `RPC_GAIN_OFF) begin
                    hit = 1'b1;
                    next_s.cfg[i].gain = merge16(s.cfg[i].gain, s.w_data, s.w_strb);
                end
                if (s.aw_addr == rbase + `RPC_BIAS_OFF) begin
                    hit = 1'b1;
                    next_s.cfg[i].bias = (merge16({5'h00, s.cfg[i].bias}, s.w_data, s.w_strb)
                        > 16'(`RPC_BIAS_MAX)) ? `RPC_BIAS_MAX
                        : 11'(merge16({5'h00, s.cfg[i].bias}, s.w_data, s.w_strb));
                end
                if (s.aw_addr == rbase + `RPC_PERIOD_OFF) begin
                    hit = 1'b1;
                    next_s.cfg[i].period = (merge16(s.cfg[i].period, s.w_data, s.w_strb)
                        > `RPC_PERIOD_MAX) ? `RPC_PERIOD_MAX
                        : merge16(s.cfg[i].period, s.w_data, s.w_strb);
                end
                if (s.aw_addr == rbase + `RPC_PULSE_OFF) begin
                    hit = 1'b1;
                    next_s.cfg[i].pulse = (merge16(s.cfg[i].pulse, s.w_data, s.w_strb)
                        > `RPC_PERIOD_MAX) ? `RPC_PERIOD_MAX
                        : merge16(s.cfg[i].pulse, s.w_data, s.w_strb);
                end
            end
            next_s.bresp = hit ? `RPC_RESP_OKAY : `RPC_RESP_SLVERR;
        end
        // read channel
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (!s.rvalid && arvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = '0;
            next_s.rresp = `RPC_RESP_SLVERR;
            if (araddr == `RPC_SPAN_OFF) begin
                next_s.rdata = {16'h0000, s.span};
                next_s.rresp = `RPC_RESP_OKAY;
            end
            if (araddr == `RPC_STATUS_OFF) begin
                next_s.rdata = 32'(relay_on);
                next_s.rresp = `RPC_RESP_OKAY;
            end
            for (int i = 0; i < N_RELAY; i++) begin
                rbase = 8'(`RPC_RELAY_BASE + i * `RPC_RELAY_STRIDE);
                if (araddr == rbase + `RPC_MODE_OFF) begin
                    next_s.rdata = {30'h00000000, s.cfg[i].mode};
                    next_s.rresp = `RPC_RESP_OKAY;
                end
                if (araddr == rbase + `RPC_SETPOINT_OFF) begin
                    next_s.rdata = {16'h0000, s.cfg[i].setpoint};
                    next_s.rresp = `RPC_RESP_OKAY;
                end
                if (araddr == rbase + `RPC_GAIN_OFF) begin
                    next_s.rdata = {16'h0000, s.cfg[i].gain};
                    next_s.rresp = `RPC_RESP_OKAY;
                end
                if (araddr == rbase + `RPC_BIAS_OFF) begin
                    next_s.rdata = {21'h000000, s.cfg[i].bias};
                    next_s.rresp = `RPC_RESP_OKAY;
                end
                if (araddr == rbase + `RPC_PERIOD_OFF) begin
                    next_s.rdata = {16'h0000, s.cfg[i].period};
                    next_s.rresp = `RPC_RESP_OKAY;
                end
                if (araddr == rbase + `RPC_PULSE_OFF) begin
                    next_s.rdata = {16'h0000, s.cfg[i].pulse};
                    next_s.rresp = `RPC_RESP_OKAY;
                end
                if (araddr == rbase + `RPC_DUTY_OFF) begin
                    next_s.rdata = {21'h000000, s.duty[i]};
                    next_s.rresp = `RPC_RESP_OKAY;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.span <= `RPC_SPAN_RST;
            for (int i = 0; i < N_RELAY; i++) begin
                s.cfg[i] <= '{mode: RPC_ON_OFF, setpoint: `RPC_SETPOINT_RST,
                    gain: `RPC_GAIN_RST, bias: `RPC_BIAS_RST,
                    period: `RPC_PERIOD_RST, pulse: `RPC_PULSE_RST};
            end
        end else begin
            s <= next_s;
        end
    end

    assign awready = !s.aw_held;
    assign wready = !s.w_held;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = !s.rvalid;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;

    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence write_pending;
        s.aw_held && s.w_held && !s.bvalid;
    endsequence

    a_write_answer: assert property (write_pending |=> bvalid ##0 (awready && wready))
        else $error("write response not given after address and data");

    a_bvalid_hold: assert property ((bvalid && !bready) |=> (bvalid && $stable(bresp)))
        else $error("write response dropped before ready");

    a_rvalid_hold: assert property ((rvalid && !rready) |=> (rvalid && $stable(rdata)))
        else $error("read data dropped before ready");

    a_read_answer: assert property ((arvalid && arready) |=> rvalid)
        else $error("read answer missing one cycle after address");

    a_duty_clamp: assert property (s.duty[0] <= `RPC_FULL_SCALE)
        else $error("output percentage above full scale");

    a_span_full: assert property (
        ($signed(s.cfg[0].gain) == 16'sd1000 && s.cfg[0].bias == 11'h000 && s.span != 16'h0
         && $signed(s.cfg[0].setpoint) - $signed(process_value) == $signed({1'b0, s.span}))
        |=> s.duty[0] == `RPC_FULL_SCALE)
        else $error("span deviation at unity gain not full output");

    a_bias_at_sp: assert property (
        (s.cfg[0].setpoint == process_value) |=> s.duty[0] == $past(s.cfg[0].bias))
        else $error("duty at setpoint differs from bias");

    a_onoff_follow: assert property (
        (aresetn && s.cfg[0].mode == RPC_ON_OFF && $stable(s.cfg[0].mode))
        |=> relay_on[0] == $past(below[0]))
        else $error("on/off relay not following setpoint compare");

    a_tick_spacing: assert property (s.tick |=> !s.tick)
        else $error("time base tick repeated");

endmodule
`default_nettype wire

// *** rpc_map.svh ***
// register offsets, reset values and timing constants of the relay pi controller
`ifndef RPC_MAP_SVH
`define RPC_MAP_SVH

`define RPC_SPAN_OFF 8'h00
`define RPC_STATUS_OFF 8'h04
`define RPC_RELAY_BASE 8'h20
`define RPC_RELAY_STRIDE 8'h20
`define RPC_MODE_OFF 8'h00
`define RPC_SETPOINT_OFF 8'h04
`define RPC_GAIN_OFF 8'h08
`define RPC_BIAS_OFF 8'h0c
`define RPC_PERIOD_OFF 8'h10
`define RPC_PULSE_OFF 8'h14
`define RPC_DUTY_OFF 8'h18

`define RPC_SPAN_RST 16'h0064
`define RPC_SETPOINT_RST 16'h03e8
`define RPC_GAIN_RST 16'h000a
`define RPC_BIAS_RST 11'h1f4
`define RPC_PERIOD_RST 16'h0000
`define RPC_PULSE_RST 16'h0000

`define RPC_FULL_SCALE 11'h3e8
`define RPC_BIAS_MAX 11'h3e8
`define RPC_PERIOD_MAX 16'hc350

`define RPC_CLK_NS 50
`define RPC_TICK_NS 100000000
`define RPC_TICK_CYCLES (`RPC_TICK_NS / `RPC_CLK_NS)

`define RPC_RESP_OKAY 2'b00
`define RPC_RESP_SLVERR 2'b10

`endif

// *** rpc_pkg.sv ***
// types shared by the relay pi controller
package rpc_pkg;

    typedef enum logic [1:0] {
        RPC_ON_OFF,
        RPC_PULSE_WIDTH,
        RPC_FREQUENCY
    } rpc_mode_t;

    typedef struct packed {
        rpc_mode_t mode;
        logic [15:0] setpoint;
        logic [15:0] gain;
        logic [10:0] bias;
        logic [15:0] period;
        logic [15:0] pulse;
    } rpc_relay_cfg_t;

    typedef struct packed {
        logic [25:0] cnt;
        logic on;
        rpc_mode_t mode_q;
    } rpc_chan_state_t;

endpackage

// *** rpc_relay_channel.sv ***
// one relay's timing: on/off, pulse width and frequency output
`timescale 1ns/100ps
`default_nettype none
`include "rpc_map.svh"

module rpc_relay_channel (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // timing
    input wire logic tick,
    input wire rpc_pkg::rpc_relay_cfg_t cfg,
    input wire logic [10:0] duty,
    input wire logic below_setpoint,
    // relay coil
    output logic relay_on
);
    import rpc_pkg::*;

    rpc_chan_state_t s;
    rpc_chan_state_t next_s;
    logic [26:0] on_time;
    logic [25:0] off_len;
    logic [10:0] div_duty;
    logic [25:0] cnt_inc;

    always_comb begin
        div_duty = (duty == 11'h000) ? 11'h001 : duty;
        on_time = 27'((cfg.period * duty) / `RPC_FULL_SCALE);
        off_len = 26'((cfg.pulse * (`RPC_FULL_SCALE - duty)) / div_duty);
        cnt_inc = s.cnt + 26'h1;
    end

    always_comb begin
        next_s = s;
        next_s.mode_q = cfg.mode;
        if (cfg.mode != s.mode_q) begin
            next_s.cnt = '0;
            next_s.on = 1'b0;
        end else begin
            unique case (cfg.mode)
                RPC_ON_OFF: begin
                    next_s.on = below_setpoint;
                    next_s.cnt = '0;
                end
                RPC_PULSE_WIDTH: begin
                    if (cfg.period == 16'h0000) begin
                        next_s.on = 1'b0;
                        next_s.cnt = '0;
                    end else begin
                        if (tick) begin
                            next_s.cnt = (cnt_inc >= 26'(cfg.period)) ? '0 : cnt_inc;
                        end
                        next_s.on = 27'(next_s.cnt) < on_time;
                    end
                end
                RPC_FREQUENCY: begin
                    if (cfg.pulse == 16'h0000 || duty == 11'h000) begin
                        next_s.on = 1'b0;
                        next_s.cnt = '0;
                    end else if (duty >= `RPC_FULL_SCALE) begin
                        next_s.on = 1'b1;
                        next_s.cnt = '0;
                    end else if (tick) begin
                        if (s.on) begin
                            if (cnt_inc >= 26'(cfg.pulse)) begin
                                next_s.on = 1'b0;
                                next_s.cnt = '0;
                            end else begin
                                next_s.cnt = cnt_inc;
                            end
                        end else begin
                            if (cnt_inc >= off_len) begin
                                next_s.on = 1'b1;
                                next_s.cnt = '0;
                            end else begin
                                next_s.cnt = cnt_inc;
                            end
                        end
                    end
                end
                default: begin
                    next_s.on = 1'b0;
                    next_s.cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '{cnt: '0, on: 1'b0, mode_q: RPC_ON_OFF};
        end else begin
            s <= next_s;
        end
    end

    assign relay_on = s.on;

    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_freq_zero_off: assert property (
        (cfg.mode == RPC_FREQUENCY && $stable(cfg.mode) && cfg.pulse == 16'h0000)
        |=> !relay_on)
        else $error("zero pulse length must keep relay released");

    a_pwm_full_on: assert property (
        (cfg.mode == RPC_PULSE_WIDTH && $stable(cfg.mode) && cfg.period != 16'h0000
         && duty >= `RPC_FULL_SCALE) |=> relay_on)
        else $error("full output must energise relay");

    a_pwm_zero_off: assert property (
        (cfg.mode == RPC_PULSE_WIDTH && duty == 11'h000) |=> !relay_on)
        else $error("zero output must release relay");

    a_freq_pulse_len: assert property (
        (cfg.mode == RPC_FREQUENCY && $stable(cfg.mode) && s.on && !tick
         && duty < `RPC_FULL_SCALE && cfg.pulse != 16'h0000 && duty != 11'h000) |=> relay_on)
        else $error("fixed pulse ended between ticks");

endmodule
`default_nettype wire

// *** rpc_pump_model.sv ***
// dosing pump model that sits on one relay coil
`timescale 1ns/100ps
`default_nettype none

module rpc_pump_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // coil and measurement control
    input wire logic coil,
    input wire logic clear,
    // measurements
    output logic [15:0] on_cycles,
    output logic [15:0] last_on,
    output logic [15:0] last_off
);
    logic prev;
    logic [15:0] run;

    // pump doses while energised; run lengths of each level are kept
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            on_cycles <= 16'h0;
            last_on <= 16'h0;
            last_off <= 16'h0;
            run <= 16'h0;
            prev <= 1'b0;
        end else begin
            prev <= coil;
            if (coil) begin
                on_cycles <= on_cycles + 16'h1;
            end
            if (coil != prev) begin
                run <= 16'h1;
                if (prev) begin
                    last_on <= run;
                end else begin
                    last_off <= run;
                end
            end else begin
                run <= run + 16'h1;
            end
        end
    end
endmodule

`default_nettype wire

// *** rpc_relay_pi_bench.sv ***
// self-checking bench of the relay pi controller
`timescale 1ns/100ps
`default_nettype none

module rpc_relay_pi_bench;
    localparam int TK = 4;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [15:0] pv = 16'h0;
    logic clr = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp, relay_on;
    logic [31:0] rdata, rdv;
    logic [15:0] on_cycles, last_on, last_off;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 32'hbca4b1d6;
    logic [31:0] rst [6] = '{32'h0, 32'h3e8, 32'ha, 32'h1f4, 32'h0, 32'h0};
    logic [15:0] cg [7] = '{16'h3e8, 16'h3e8, 16'h1f4, 16'h3e8, 16'h3e8, 16'hfc18, 16'h7d0};
    logic [15:0] cb [7] = '{16'h0, 16'h0, 16'h0, 16'h1f4, 16'h1f4, 16'h1f4, 16'h0};
    logic [15:0] cp [7] = '{16'h32, 16'h28, 16'h32, 16'h46, 16'h64, 16'h64, 16'h41};
    logic [15:0] tp [5] = '{16'ha, 16'ha, 16'ha, 16'h0, 16'h5};
    logic [15:0] pp [5] = '{16'hffe2, 16'hff38, 16'h64, 16'hffe2, 16'hffce};

    always #25 aclk = ~aclk;

    rpc_relay_pi #(.N_RELAY(2), .TICK_CYCLES(TK)) u_rpc_relay_pi (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .process_value(pv), .relay_on(relay_on)
    );

    rpc_pump_model u_rpc_pump_model (
        .aclk(aclk), .aresetn(aresetn), .coil(relay_on[0]), .clear(clr),
        .on_cycles(on_cycles), .last_on(last_on), .last_off(last_off)
    );

    task final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rdv = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    task cfg(input logic [7:0] base, input logic [15:0] m, sp, g, b);
        wr(base, {16'h0, m});
        wr(base + 8'h04, {16'h0, sp});
        wr(base + 8'h08, {16'h0, g});
        wr(base + 8'h0c, {16'h0, b});
    endtask

    task clear_wait(input int n);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (n) @(posedge aclk);
        #1;
    endtask

    function automatic logic [31:0] exp_duty(input logic [15:0] g, b, sp, p, sn);
        longint v;
        v = longint'(b) + longint'($signed(g)) * (longint'($signed(sp)) - longint'($signed(p)))
            / longint'(sn);
        if (v < 0) v = 0;
        if (v > 1000) v = 1000;
        return 32'(v);
    endfunction

    initial begin
        int i;
        int j;
        logic [15:0] g, b, sp, p;
        logic [7:0] base;
        logic [31:0] d;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00);
        chk("span", rdv, 32'h64);
        for (i = 0; i < 6; i++) begin
            rd(8'h20 + 8'(4 * i));
            chk("reset value", rdv, rst[i]);
        end
        rd(8'h38);
        chk("reset duty", rdv, exp_duty(16'ha, 16'h1f4, 16'h3e8, 16'h0, 16'h64));
        rd(8'h04);
        chk("status", rdv, 32'h3);
        rd(8'h1c);
        chk("unmapped rresp", {30'h0, rsp}, 32'h2);
        wr(8'h1c, 32'h5);
        chk("unmapped bresp", {30'h0, rsp}, 32'h2);
        $display("test reset done");
        // proportional action only
        wr(8'h00, 32'h14);
        for (i = 0; i < 17; i++) begin
            if (i < 7) begin
                g = cg[i];
                b = cb[i];
                sp = 16'h46;
                p = cp[i];
            end else begin
                g = 16'($random(seed));
                b = 16'($unsigned($random(seed)) % 1001);
                sp = 16'($random(seed) % 2000);
                p = 16'($random(seed) % 2000);
            end
            base = 8'h20 + 8'(32 * (i % 2));
            pv <= p;
            cfg(base, 16'h0, sp, g, b);
            repeat (2) @(posedge aclk);
            rd(base + 8'h18);
            chk("duty", rdv, exp_duty(g, b, sp, p, 16'h14));
        end
        $display("test duty done");
        for (i = 0; i < 4; i++) begin
            cfg(8'h40, 16'(3 * (i / 2)), 16'h64, 16'h7fff, 16'h0);
            pv <= (i % 2) ? 16'h96 : 16'h32;
            repeat (4) @(posedge aclk);
            chk("on off relay", {31'h0, relay_on[1]}, 32'(i % 2 == 0));
        end
        $display("test on off done");
        wr(8'h00, 32'h64);
        cfg(8'h20, 16'h1, 16'h0, 16'h3e8, 16'h0);
        for (j = 0; j < 5; j++) begin
            wr(8'h30, {16'h0, tp[j]});
            pv <= pp[j];
            repeat (100) @(posedge aclk);
            clear_wait(400);
            d = exp_duty(16'h3e8, 16'h0, 16'h0, pp[j], 16'h64);
            chk("pulse width on", on_cycles,
                (tp[j] == 0) ? 0 : 400 / (tp[j] * TK) * (tp[j] * d / 1000) * TK);
        end
        $display("test pulse width done");
        wr(8'h34, 32'h2);
        wr(8'h20, 32'h2);
        for (j = 0; j < 2; j++) begin
            pv <= j ? 16'hffe7 : 16'hffce;
            repeat (100) @(posedge aclk);
            clear_wait(200);
            d = exp_duty(16'h3e8, 16'h0, 16'h0, j ? 16'hffe7 : 16'hffce, 16'h64);
            chk("pulse on", last_on, 2 * TK);
            chk("pulse off", last_off, TK * (2 * (1000 - d) / d));
        end
        wr(8'h34, 32'h0);
        repeat (100) @(posedge aclk);
        clear_wait(200);
        chk("zero pulse", on_cycles, 32'h0);
        $display("test frequency done");
        final_report();
    end
endmodule

`default_nettype wire
